// file: twdp_defines.vh
// Purpose: Constants for the two-wire digital potentiometer core
// Assumes: Included by bare name from the core and the bench
// Notes: Device-type code value is arbitrary, not a real maker code
`ifndef TWDP_DEFINES_VH
`define TWDP_DEFINES_VH

// -----------------------------------------------------------
// Addressing
// -----------------------------------------------------------
`define TWDP_TYPE_CODE 4'ha
`define TWDP_ADDR_BITS 3

// -----------------------------------------------------------
// Registers
// -----------------------------------------------------------
`define TWDP_REG_WIDTH 8
`define TWDP_WIPER_RESET 8'h00
`define TWDP_SCRATCH_RESET 8'h00
`define TWDP_TAP_COUNT 256

// -----------------------------------------------------------
// Command bytes (write: low two bits pick target registers)
// -----------------------------------------------------------
`define TWDP_CMD_SCRATCH 8'ha9
`define TWDP_CMD_WIPER 8'haa
`define TWDP_CMD_BOTH 8'haf

`endif

// file: twdp_sync.v
// Purpose: Two-flop synchroniser for one input pin (bus or address select)
// Assumes: Input is asynchronous to mclk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module twdp_sync (
  mclk,
  rst,
  pinIn,
  pinSync
);
  input wire mclk;
  input wire rst;
  input wire pinIn;
  output reg pinSync;

  reg stage1_reg;

  always @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      stage1_reg <= pinIn;
      pinSync <= stage1_reg;
    end
  end
endmodule

// file: twdp_core.v
// Purpose: Two-wire slave holding a scratch byte and a 256-tap wiper code
// Assumes: mclk 100 MHz, far faster than SCL; rst is synchronous active high
// Notes: Tap select output is one-hot over the resistor array
// How it works
// - 8-bit scratch byte, written and read back, touches nothing analog.
// - Wiper byte drives a one-of-256 tap selector.
// - Code 00h picks the low end, FFh one step below high end.
// - Wiper clears to 00h on power-up and reset.
// - Three select inputs form the low address bits.
// - Address byte must match type code and select bits to acknowledge.
// - Address LSB one means read, zero means write.
// - Reads return scratch first, then wiper; master NACK ends transfer.
// - Bytes move MSB first; the receiver drives the acknowledge.
`timescale 1ns/100ps
`include "twdp_defines.vh"
module twdp_core (
  mclk,
  rst,
  sclIn,
  sdaIn,
  sdaOut,
  sdaOe_n,
  addrSelectBit0,
  addrSelectBit1,
  addrSelectBit2,
  tapSelect,
  scratchByte,
  wiperPosition
);
  parameter W = `TWDP_REG_WIDTH;
  parameter TAPS = `TWDP_TAP_COUNT;
  input wire mclk;
  input wire rst;
  input wire sclIn;
  input wire sdaIn;
  output wire sdaOut;
  output wire sdaOe_n;
  input wire addrSelectBit0;
  input wire addrSelectBit1;
  input wire addrSelectBit2;
  output reg [TAPS-1:0] tapSelect;
  output wire [W-1:0] scratchByte;
  output wire [W-1:0] wiperPosition;

  // -----------------------------------------------------------
  // Pin synchronisers and edge detection
  // -----------------------------------------------------------
  wire sclS;
  wire sdaS;
  wire a0S;
  wire a1S;
  wire a2S;
  twdp_sync uSyncScl (.mclk(mclk), .rst(rst), .pinIn(sclIn), .pinSync(sclS));
  twdp_sync uSyncSda (.mclk(mclk), .rst(rst), .pinIn(sdaIn), .pinSync(sdaS));
  twdp_sync uSyncA0 (.mclk(mclk), .rst(rst), .pinIn(addrSelectBit0), .pinSync(a0S));
  twdp_sync uSyncA1 (.mclk(mclk), .rst(rst), .pinIn(addrSelectBit1), .pinSync(a1S));
  twdp_sync uSyncA2 (.mclk(mclk), .rst(rst), .pinIn(addrSelectBit2), .pinSync(a2S));

  reg sclPrev_reg;
  reg sdaPrev_reg;
  always @(posedge mclk) begin
    if (rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end
  wire sclRise = sclS & ~sclPrev_reg;
  wire sclFall = ~sclS & sclPrev_reg;
  wire startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  wire stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

  // -----------------------------------------------------------
  // Protocol state machine
  // -----------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_MACK = 3'd5;

  reg [2:0] state_reg;
  reg [2:0] bitCnt_reg;
  reg [W-1:0] shift_reg;
  reg isRead_reg;
  reg drvLow_reg;
  reg [1:0] rxIdx_reg;
  reg [1:0] target_reg;
  reg txIdx_reg;
  reg ackPending_reg;
  reg [W-1:0] scratch_reg;
  reg [W-1:0] wiper_reg;

  wire [6:0] myAddr = {`TWDP_TYPE_CODE, a2S, a1S, a0S};
  wire [W-1:0] rxByte = {shift_reg[W-2:0], sdaS};
  wire [W-1:0] txByte = txIdx_reg ? wiper_reg : scratch_reg;

  assign sdaOut = 1'b0;
  assign sdaOe_n = ~drvLow_reg;
  assign scratchByte = scratch_reg;
  assign wiperPosition = wiper_reg;

  always @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 3'd0;
      shift_reg <= {W{1'b0}};
      isRead_reg <= 1'b0;
      drvLow_reg <= 1'b0;
      rxIdx_reg <= 2'd0;
      target_reg <= 2'd0;
      txIdx_reg <= 1'b0;
      ackPending_reg <= 1'b0;
      scratch_reg <= `TWDP_SCRATCH_RESET;
      wiper_reg <= `TWDP_WIPER_RESET;
    end else if (startCond) begin
      // Repeated start is handled like a fresh one
      state_reg <= ST_ADDR;
      bitCnt_reg <= 3'd0;
      drvLow_reg <= 1'b0;
      rxIdx_reg <= 2'd0;
      txIdx_reg <= 1'b0;
    end else if (stopCond) begin
      state_reg <= ST_IDLE;
      drvLow_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (sclRise) begin
            shift_reg <= rxByte;
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (bitCnt_reg == 3'd7) begin
              isRead_reg <= sdaS;
              ackPending_reg <= (shift_reg[6:0] == myAddr);
              state_reg <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          // Ack drive starts after the eighth clock falls, released after ninth
          if (sclFall && !drvLow_reg) begin
            if (ackPending_reg) begin
              drvLow_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end else if (sclFall && drvLow_reg) begin
            drvLow_reg <= 1'b0;
            ackPending_reg <= 1'b0;
            bitCnt_reg <= 3'd0;
            if (isRead_reg) begin
              state_reg <= ST_TX;
              drvLow_reg <= ~txByte[W-1];
              shift_reg <= {txByte[W-2:0], 1'b1};
            end else begin
              state_reg <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (sclRise) begin
            shift_reg <= rxByte;
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (bitCnt_reg == 3'd7) begin
              ackPending_reg <= 1'b1;
              state_reg <= ST_ACK;
              if (rxIdx_reg == 2'd0) begin
                target_reg <= rxByte[1:0];
                rxIdx_reg <= 2'd1;
              end else begin
                // Data bytes fill the selected targets in order; extras are acked and dropped
                if ((rxIdx_reg == 2'd1) && target_reg[0]) begin
                  scratch_reg <= rxByte;
                end else if (((rxIdx_reg == 2'd1) && (target_reg == 2'b10)) ||
                             ((rxIdx_reg == 2'd2) && (target_reg == 2'b11))) begin
                  wiper_reg <= rxByte;
                end
                if (rxIdx_reg != 2'd3) begin
                  rxIdx_reg <= rxIdx_reg + 2'd1;
                end
              end
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (bitCnt_reg == 3'd7) begin
              drvLow_reg <= 1'b0;
              state_reg <= ST_MACK;
            end else begin
              drvLow_reg <= ~shift_reg[W-1];
              shift_reg <= {shift_reg[W-2:0], 1'b1};
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            ackPending_reg <= ~sdaS;
          end else if (sclFall) begin
            if (ackPending_reg) begin
              // Scratch then wiper; past the wiper keep returning it
              bitCnt_reg <= 3'd0;
              txIdx_reg <= 1'b1;
              drvLow_reg <= ~wiper_reg[W-1];
              shift_reg <= {wiper_reg[W-2:0], 1'b1};
              state_reg <= ST_TX;
            end else begin
              state_reg <= ST_IDLE;
            end
            ackPending_reg <= 1'b0;
          end
        end
        default: begin
          drvLow_reg <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------
  // One-of-256 tap decode; code 0 is the low terminal
  // -----------------------------------------------------------
  wire [TAPS-1:0] tapHit;
  genvar t;
  generate
    for (t = 0; t < TAPS; t = t + 1) begin : gTap
      // Compare at integer width so the loop index is never part-selected
      assign tapHit[t] = ({{(32-W){1'b0}}, wiper_reg} == t);
    end
  endgenerate

  always @(posedge mclk) begin
    if (rst) begin
      tapSelect <= {{(TAPS-1){1'b0}}, 1'b1};
    end else begin
      tapSelect <= tapHit;
    end
  end
endmodule

// file: twdp_core_sva.sv
// Purpose: Port assertions for the pot core
// Assumes: One clock domain, synchronous reset
// Notes: Bound to the core from the bench
`timescale 1ns/100ps
module twdp_core_sva #(
  parameter W = 8,
  parameter TAPS = 256
) (
  input wire mclk,
  input wire rst,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe_n,
  input wire addrSelectBit0,
  input wire addrSelectBit1,
  input wire addrSelectBit2,
  input wire [TAPS-1:0] tapSelect,
  input wire [W-1:0] scratchByte,
  input wire [W-1:0] wiperPosition
);
  wire [TAPS-1:0] tapOne = {{(TAPS-1){1'b0}}, 1'b1};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_tap_one_hot: assert property (1'b1 |=> tapSelect == (tapOne << $past(wiperPosition)))
    else $error("tap select does not follow wiper code");
  a_reset_clears: assert property (disable iff (1'b0) rst |=> !wiperPosition && !scratchByte && sdaOe_n)
    else $error("reset did not clear registers");
  a_sda_never_high: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  a_regs_on_scl: assert property ($changed({wiperPosition, scratchByte}) |-> sclIn)
    else $error("register changed outside clock high phase");
  a_drive_scl_low: assert property ($changed(sdaOe_n) |-> !sclIn)
    else $error("data output moved while clock high");
  a_drive_holds: assert property ($fell(sdaOe_n) |-> !sdaOe_n [*8])
    else $error("driven low bit too short");
  a_quiet_at_start: assert property (sclIn && $fell(sdaIn) |-> sdaOe_n)
    else $error("device driving at start");
  a_quiet_at_stop: assert property (sclIn && $rose(sdaIn) |-> sdaOe_n)
    else $error("device driving at stop");
endmodule

// file: twdp_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Pull-up on the data wire
// Notes: q sets quarter bit time in mclk cycles
`timescale 1ns/100ps
module twdp_master (
  input wire mclk,
  input wire sdaWire,
  output logic sclOut = 1'b1,
  output logic sdaLow = 1'b0
);
  integer q = 4;
  task qw;
    repeat (q) @(negedge mclk);
  endtask
  task start;
    sdaLow = 1'b0;
    sclOut = 1'b1;
    qw;
    sdaLow = 1'b1;
    qw;
    sclOut = 1'b0;
    qw;
  endtask
  task stop;
    sdaLow = 1'b1;
    qw;
    sclOut = 1'b1;
    qw;
    sdaLow = 1'b0;
    qw;
  endtask
  // Open drain: a one is sent by releasing, so the slave may pull it low
  task xbit(input b, output r);
    sdaLow = !b;
    qw;
    sclOut = 1'b1;
    qw;
    r = sdaWire;
    qw;
    sclOut = 1'b0;
    qw;
  endtask
  task xbyte(input [7:0] d, output [7:0] r);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      xbit(d[i], r[i]);
    end
  endtask
endmodule

// file: twdp_core_bench.sv
// Purpose: Self-checking bench for the pot core
// Assumes: Master model on the bus side
// Notes: Data values other than 00h and FFh differ from their bit reversal
`timescale 1ns/100ps
`include "twdp_defines.vh"
module twdp_core_bench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] sel = 3'h5;
  wire sclLine, mLow, sdaOut, sdaOe_n;
  wire [255:0] tap;
  wire [7:0] scr, wip;
  wire sdaLine = !(mLow || (!sdaOe_n && !sdaOut));
  integer n_errors = 0, checked = 0, cyc = 0;
  initial forever #5 mclk = ~mclk;
  twdp_master u_m (.mclk(mclk), .sdaWire(sdaLine), .sclOut(sclLine), .sdaLow(mLow));
  twdp_core u_dut (.mclk(mclk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .addrSelectBit0(sel[0]), .addrSelectBit1(sel[1]), .addrSelectBit2(sel[2]), .tapSelect(tap),
    .scratchByte(scr), .wiperPosition(wip));
  task chk(input c);
    checked = checked + 1;
    if (!c) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: check %0d", $time, checked);
    end
  endtask
  task send(input [7:0] d);
    reg [7:0] r;
    reg a;
    u_m.xbyte(d, r);
    u_m.xbit(1'b1, a);
    chk(a === 1'b0);
  endtask
  task t_reset;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk(wip === 8'h00 && scr === 8'h00 && tap === 256'h1 && sdaOe_n === 1'b1);
  endtask
  task wr(input [7:0] cmd, d0, d1, es, ew);
    u_m.start;
    send({`TWDP_TYPE_CODE, sel, 1'b0});
    send(cmd);
    send(d0);
    send(d1);
    u_m.stop;
    chk(scr === es && wip === ew);
    chk(tap === (256'h1 << ew));
  endtask
  task rd(input [7:0] es, ew);
    reg [7:0] s, w;
    reg a;
    u_m.start;
    send({`TWDP_TYPE_CODE, sel, 1'b1});
    u_m.xbyte(8'hff, s);
    u_m.xbit(1'b0, a);
    u_m.xbyte(8'hff, w);
    u_m.xbit(1'b1, a);
    u_m.stop;
    chk(s === es && w === ew);
  endtask
  task nak(input [7:0] ad);
    reg [7:0] r;
    reg a;
    u_m.start;
    u_m.xbyte(ad, r);
    u_m.xbit(1'b1, a);
    chk(a === 1'b1);
    u_m.xbyte(8'haa, r);
    u_m.xbit(1'b1, a);
    u_m.xbyte(8'h77, r);
    u_m.xbit(1'b1, a);
    u_m.stop;
    chk(wip === 8'h96);
  endtask
  task tally_and_finish;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    @(negedge mclk);
    t_reset;
    wr(8'ha9, 8'h1e, 8'h11, 8'h1e, 8'h00);
    wr(8'haa, 8'hff, 8'h22, 8'h1e, 8'hff);
    wr(8'haf, 8'hc1, 8'h96, 8'hc1, 8'h96);
    rd(8'hc1, 8'h96);
    nak({`TWDP_TYPE_CODE ^ 4'h1, sel, 1'b0});
    nak({`TWDP_TYPE_CODE, sel ^ 3'h4, 1'b0});
    sel = 3'h2;
    nak({`TWDP_TYPE_CODE, 3'h5, 1'b0});
    u_m.q = 9;
    wr(8'haa, 8'h00, 8'h33, 8'hc1, 8'h00);
    t_reset;
    wr(8'haa, 8'h80, 8'h44, 8'h00, 8'h80);
    rd(8'h00, 8'h80);
    tally_and_finish;
  end
endmodule
bind twdp_core twdp_core_sva #(.W(W), .TAPS(TAPS)) u_sva (.mclk(mclk), .rst(rst), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrSelectBit0(addrSelectBit0),
  .addrSelectBit1(addrSelectBit1), .addrSelectBit2(addrSelectBit2), .tapSelect(tapSelect),
  .scratchByte(scratchByte), .wiperPosition(wiperPosition));
